/* File: rtl/rpc_consts.svh */
// register offsets, field positions, reset words and write masks of the pad configuration block
// assumes byte addressing on a 32-bit APB, one aligned word per register
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH

// ============================================================
// register offsets
`define RPC_OFS_DAC1 12'h084
`define RPC_OFS_DAC2 12'h088
`define RPC_OFS_XTAL 12'h08C
`define RPC_OFS_TGLOB 12'h090
`define RPC_OFS_TPAD0 12'h094
`define RPC_OFS_WAKE 12'h0BC
`define RPC_OFS_XPDSEL 12'h0C0
`define RPC_OFS_I2CSEL 12'h0C4
`define RPC_OFS_FIRST 12'h084
`define RPC_OFS_LAST 12'h0C4

// ============================================================
// register indices within the contiguous window
`define RPC_IDX_DAC1 5'h00
`define RPC_IDX_DAC2 5'h01
`define RPC_IDX_XTAL 5'h02
`define RPC_IDX_TGLOB 5'h03
`define RPC_IDX_TPAD0 5'h04
`define RPC_IDX_WAKE 5'h0E
`define RPC_IDX_XPDSEL 5'h0F
`define RPC_IDX_I2CSEL 5'h10
`define RPC_NREGS 17

// ============================================================
// pad indices
`define RPC_PAD_DAC1 0
`define RPC_PAD_DAC2 1
`define RPC_PAD_XN 2
`define RPC_PAD_XP 3
`define RPC_PAD_T0 4
`define RPC_NPADS 14
`define RPC_NTOUCH 10
`define RPC_NLP 18

// ============================================================
// field positions
`define RPC_PADCFG_LSB 0
`define RPC_PADCFG_MSB 10
`define RPC_XPCFG_LSB 11
`define RPC_XPCFG_MSB 21
`define RPC_DAC_VAL_LSB 11
`define RPC_DAC_VAL_MSB 18
`define RPC_DAC_PWR 19
`define RPC_DAC_FORCE 20
`define RPC_XT_BIAS_LSB 22
`define RPC_XT_BIAS_MSB 23
`define RPC_XT_PWR 24
`define RPC_XT_DRES_LSB 25
`define RPC_XT_DRES_MSB 26
`define RPC_XT_DBIAS_LSB 27
`define RPC_XT_DBIAS_MSB 28
`define RPC_TG_BIAS_PWR 0
`define RPC_TG_DREFH_LSB 1
`define RPC_TG_DREFH_MSB 2
`define RPC_TG_DREFL_LSB 3
`define RPC_TG_DREFL_MSB 4
`define RPC_TG_DRANGE_LSB 5
`define RPC_TG_DRANGE_MSB 6
`define RPC_TG_TOUCH_BIAS_CURRENT_LSB 7
`define RPC_TG_TOUCH_BIAS_CURRENT_MSB 8
`define RPC_TG_BIAS_SLEEP 9
`define RPC_TP_SLOPE_LSB 11
`define RPC_TP_SLOPE_MSB 13
`define RPC_TP_START 14
`define RPC_TP_TIE 15
`define RPC_TP_XPD 16
`define RPC_TP_TODIG 17
`define RPC_SEL_LSB 0
`define RPC_SEL_MSB 4
`define RPC_I2C_SDA 0
`define RPC_I2C_SCL 1

// ============================================================
// reset words and writable masks
`define RPC_RST_ZERO 32'h0000_0000
`define RPC_RST_TPAD 32'h0000_2000
`define RPC_MSK_DAC 32'h001F_FFFF
`define RPC_MSK_XTAL 32'h1FFF_FFFF
`define RPC_MSK_TGLOB 32'h0000_03FF
`define RPC_MSK_TPAD 32'h0003_FFFF
`define RPC_MSK_SEL 32'h0000_001F
`define RPC_MSK_I2C 32'h0000_0003

`endif

/* File: rtl/rpc_pkg.sv */
// types shared by the pad configuration block
// assumes nothing beyond the constants header
package rpc_pkg;

	// per-pad configuration field group, route select in bit 0
	typedef struct packed {
		logic [1:0] drive_strength;
		logic pullup_enable;
		logic pulldown_enable;
		logic hold;
		logic normal_input_enable;
		logic sleep_output_enable;
		logic sleep_input_enable;
		logic sleep_config_select;
		logic lowpower_function_select;
		logic domain_route_select;
	} rpc_pad_cfg_t;

	// electrical controls handed to one pad cell
	typedef struct packed {
		logic [1:0] drive_strength;
		logic pullup_enable;
		logic pulldown_enable;
		logic input_enable;
	} rpc_pad_elec_t;

	// output value and enable offered by one source
	typedef struct packed {
		logic value;
		logic enable;
	} rpc_drive_t;

endpackage

/* File: rtl/rpc_pad_ctrl.sv */
// resolution of one low-power pad: routing, function select, sleep set, hold
// assumes the pad input comes straight from the pin, other sources share i_ref_clk
`include "rpc_consts.svh"

module rpc_pad_ctrl
	import rpc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input rpc_pad_cfg_t i_cfg,
	input rpc_drive_t i_dig_drv,
	input rpc_drive_t i_lp_fn0_drv,
	input rpc_drive_t i_lp_fn1_drv,
	input wire logic i_pad_in,
	output logic o_pad_out,
	output logic o_pad_oe_n,
	output rpc_pad_elec_t o_elec,
	output logic o_dig_in,
	output logic o_lp_in
);

	logic sync1_q;
	logic sync2_q;
	rpc_drive_t src;
	logic oe_now;
	logic ie_now;
	logic out_q;
	logic oe_n_q;
	rpc_pad_elec_t elec_q;
	logic dig_in_q;
	logic lp_in_q;

	// ============================================================
	// pin synchroniser
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= i_pad_in;
			sync2_q <= sync1_q;
		end
	end

	// ============================================================
	// source and enable selection
	always_comb begin
		if (i_cfg.domain_route_select) begin // [R01]
			src = i_cfg.lowpower_function_select ? i_lp_fn1_drv : i_lp_fn0_drv; // [R09]
		end else begin
			src = i_dig_drv;
		end
		if (i_cfg.sleep_config_select) begin // [R05]
			oe_now = i_cfg.sleep_output_enable; // [R07]
			ie_now = i_cfg.sleep_input_enable; // [R06]
		end else begin
			oe_now = src.enable;
			ie_now = i_cfg.normal_input_enable; // [R08]
		end
	end

	// ============================================================
	// pad drive, frozen while hold is set
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			out_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else if (!i_cfg.hold) begin // [R02]
			out_q <= src.value;
			oe_n_q <= ~oe_now;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			elec_q <= '0;
		end else begin
			elec_q.drive_strength <= i_cfg.drive_strength; // [R10]
			elec_q.pullup_enable <= i_cfg.pullup_enable; // [R04]
			elec_q.pulldown_enable <= i_cfg.pulldown_enable; // [R03]
			elec_q.input_enable <= ie_now;
		end
	end

	// ============================================================
	// input delivered to the selected domain only
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			dig_in_q <= 1'b0;
			lp_in_q <= 1'b0;
		end else begin
			dig_in_q <= ie_now & ~i_cfg.domain_route_select & sync2_q; // [R01]
			lp_in_q <= ie_now & i_cfg.domain_route_select & sync2_q;
		end
	end

	assign o_pad_out = out_q;
	assign o_pad_oe_n = oe_n_q;
	assign o_elec = elec_q;
	assign o_dig_in = dig_in_q;
	assign o_lp_in = lp_in_q;

endmodule

/* File: rtl/rpc_pad_select.sv */
// wake-up source and crystal power-down source selection among the low-power pads
// assumes raw pin levels in, invert bit from logic on the same clock
`include "rpc_consts.svh"

module rpc_pad_select
	import rpc_pkg::*;
#(
	parameter int NLP = `RPC_NLP
)
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [NLP-1:0] i_lp_lvl,
	input wire logic [4:0] i_wake_sel,
	input wire logic [4:0] i_xpd_sel,
	input wire logic i_xtal_conf_invert,
	output logic o_wake_lvl,
	output logic o_xtal_pd_en
);

	logic [NLP-1:0] sync1_q;
	logic [NLP-1:0] sync2_q;
	logic wake_q;
	logic xpd_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= i_lp_lvl;
			sync2_q <= sync1_q;
		end
	end

	// out-of-range selections read as low
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			wake_q <= 1'b0;
			xpd_q <= 1'b0;
		end else begin
			wake_q <= (32'(i_wake_sel) < NLP) ? sync2_q[i_wake_sel] : 1'b0; // [R18]
			xpd_q <= ((32'(i_xpd_sel) < NLP) ? sync2_q[i_xpd_sel] : 1'b0) ^ i_xtal_conf_invert; // [R19]
		end
	end

	assign o_wake_lvl = wake_q;
	assign o_xtal_pd_en = xpd_q;

endmodule

/* File: rtl/rpc_top.sv */
// low-power pad configuration registers with APB slave and per-pad resolution
// assumes a single 100 MHz clock, synchronous reset, pad pins arriving asynchronously
//
// Overview of operation
// [R01] route bit: 0 digital mux, 1 low-power
// [R02] hold bit freezes the pad output
// [R03] pull-down enabled when bit is 1
// [R04] pull-up enabled when bit is 1
// [R05] sleep select swaps in sleep enables
// [R06] sleep input enable gates input buffer
// [R07] sleep output enable gates output driver
// [R08] normal input enable gates input buffer
// [R09] function select picks low-power function 0/1
// [R10] drive strength field sets pad drive
// [R11] software tristates converter pad before power-on
// [R12] converter value passed, powered while bit set; the code also powers it while the force bit is set
// [R13] touch slope field three bits, resets 100
// [R14] tie option: 0 low, 1 high
// [R15] touch power bit and measurement start bit
// [R16] shared bias power bit powers bias
// [R17] bias current applies only with bias sleep
// [R18] wake-up field selects one low-power pad
// [R19] crystal power-down: pad level xor invert bit
// [R20] I2C data on touch pad 1 or 3
// [R21] I2C clock on touch pad 0 or 2
// [R22] power-up bit enables slow crystal oscillator
// [R23] fields read back and drive controls directly
//
// The APB register port was decided locally.
`include "rpc_consts.svh"

module rpc_top
	import rpc_pkg::*;
#(
	parameter int NPADS = `RPC_NPADS,
	parameter int NTOUCH = `RPC_NTOUCH,
	parameter int NLP = `RPC_NLP
)
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input rpc_drive_t [NPADS-1:0] i_dig_drv,
	input rpc_drive_t [NPADS-1:0] i_lp_fn0_drv,
	input rpc_drive_t [NPADS-1:0] i_lp_fn1_drv,
	input wire logic [NPADS-1:0] i_pad_in,
	output logic [NPADS-1:0] o_pad_out,
	output logic [NPADS-1:0] o_pad_oe_n,
	output rpc_pad_elec_t [NPADS-1:0] o_pad_elec,
	output logic [NPADS-1:0] o_dig_in,
	output logic [NPADS-1:0] o_lp_in,
	output logic [7:0] o_dac1_value,
	output logic o_dac1_power_on,
	output logic [7:0] o_dac2_value,
	output logic o_dac2_power_on,
	output logic o_slow_xtal_power_up,
	output logic [1:0] o_slow_xtal_bias_dac,
	output logic [1:0] o_slow_xtal_dres,
	output logic [1:0] o_slow_xtal_dbias,
	output logic o_touch_bias_power,
	output logic [1:0] o_touch_refh,
	output logic [1:0] o_touch_refl,
	output logic [1:0] o_touch_range,
	output logic [1:0] o_touch_bias_current,
	output logic [NTOUCH-1:0][2:0] o_touch_slope,
	output logic [NTOUCH-1:0] o_touch_start,
	output logic [NTOUCH-1:0] o_touch_start_pulse,
	output logic [NTOUCH-1:0] o_touch_tie_level,
	output logic [NTOUCH-1:0] o_touch_power_on,
	output logic [NTOUCH-1:0] o_touch_input_to_digital,
	input wire logic [NLP-1:0] i_lp_pad_lvl,
	input wire logic i_xtal_conf_invert,
	output logic o_wake_lvl,
	output logic o_xtal_pd_en,
	input wire logic i_i2c_scl_pull_low,
	input wire logic i_i2c_sda_pull_low,
	output logic o_i2c_scl_in,
	output logic o_i2c_sda_in
);

	logic [31:0] regs_q [`RPC_NREGS];
	logic [31:0] rdata_q;
	logic slverr_q;
	logic setup;
	logic access;
	logic hit;
	logic aligned;
	logic [11:0] rel_addr;
	logic [4:0] idx;
	logic [31:0] lane_mask;
	logic [NTOUCH-1:0] start_prev_q;
	rpc_pad_cfg_t [NPADS-1:0] pad_cfg;
	rpc_drive_t [NPADS-1:0] fn1_drv;
	logic sda_sel;
	logic scl_sel;
	logic [7:0] dac1_val_q;
	logic [7:0] dac2_val_q;
	logic dac1_pwr_q;
	logic dac2_pwr_q;
	logic i2c_scl_q;
	logic i2c_sda_q;

	// ============================================================
	// register reset words and writable bits
	function automatic logic [31:0] rpc_mask(input logic [4:0] i);
		logic [31:0] m;
		m = `RPC_MSK_TPAD;
		unique case (i)
			`RPC_IDX_DAC1, `RPC_IDX_DAC2: m = `RPC_MSK_DAC;
			`RPC_IDX_XTAL: m = `RPC_MSK_XTAL;
			`RPC_IDX_TGLOB: m = `RPC_MSK_TGLOB;
			`RPC_IDX_WAKE, `RPC_IDX_XPDSEL: m = `RPC_MSK_SEL;
			`RPC_IDX_I2CSEL: m = `RPC_MSK_I2C;
			default: m = `RPC_MSK_TPAD;
		endcase
		return m;
	endfunction

	function automatic logic [31:0] rpc_reset(input logic [4:0] i);
		logic [31:0] r;
		r = `RPC_RST_ZERO;
		if (i >= `RPC_IDX_TPAD0 && i < `RPC_IDX_WAKE) begin
			r = `RPC_RST_TPAD; // [R13]
		end
		return r;
	endfunction

	// ============================================================
	// APB decode
	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable;
	assign rel_addr = i_paddr - `RPC_OFS_FIRST;
	assign idx = rel_addr[6:2];
	assign aligned = (i_paddr[1:0] == 2'h0);
	assign hit = aligned && (i_paddr >= `RPC_OFS_FIRST) && (i_paddr <= `RPC_OFS_LAST);

	always_comb begin
		lane_mask = '0;
		for (int b = 0; b < 4; b++) begin
			lane_mask[b*8 +: 8] = {8{i_pstrb[b]}};
		end
	end

	// read data and error captured in the setup cycle, answered in the first access cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			rdata_q <= '0;
			slverr_q <= 1'b0;
		end else if (setup) begin
			slverr_q <= ~hit;
			rdata_q <= (hit && !i_pwrite) ? regs_q[idx] : '0; // [R23]
		end
	end

	assign o_pready = 1'b1;
	assign o_prdata = rdata_q;
	assign o_pslverr = slverr_q;

	// ============================================================
	// register file
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			for (int r = 0; r < `RPC_NREGS; r++) begin
				regs_q[r] <= rpc_reset(5'(r));
			end
		end else if (access && i_pwrite && hit) begin
			regs_q[idx] <= (regs_q[idx] & ~(lane_mask & rpc_mask(idx))) // [R23]
				| (i_pwdata & lane_mask & rpc_mask(idx));
		end
	end

	// ============================================================
	// per-pad configuration fields
	assign pad_cfg[`RPC_PAD_DAC1] = rpc_pad_cfg_t'(regs_q[`RPC_IDX_DAC1][`RPC_PADCFG_MSB:`RPC_PADCFG_LSB]);
	assign pad_cfg[`RPC_PAD_DAC2] = rpc_pad_cfg_t'(regs_q[`RPC_IDX_DAC2][`RPC_PADCFG_MSB:`RPC_PADCFG_LSB]);
	assign pad_cfg[`RPC_PAD_XN] = rpc_pad_cfg_t'(regs_q[`RPC_IDX_XTAL][`RPC_PADCFG_MSB:`RPC_PADCFG_LSB]);
	assign pad_cfg[`RPC_PAD_XP] = rpc_pad_cfg_t'(regs_q[`RPC_IDX_XTAL][`RPC_XPCFG_MSB:`RPC_XPCFG_LSB]);

	genvar t;
	generate
		for (t = 0; t < NTOUCH; t++) begin : g_touch
			assign pad_cfg[`RPC_PAD_T0 + t] =
				rpc_pad_cfg_t'(regs_q[`RPC_IDX_TPAD0 + t][`RPC_PADCFG_MSB:`RPC_PADCFG_LSB]);
			assign o_touch_slope[t] = regs_q[`RPC_IDX_TPAD0 + t][`RPC_TP_SLOPE_MSB:`RPC_TP_SLOPE_LSB]; // [R13]
			assign o_touch_start[t] = regs_q[`RPC_IDX_TPAD0 + t][`RPC_TP_START]; // [R15]
			assign o_touch_tie_level[t] = regs_q[`RPC_IDX_TPAD0 + t][`RPC_TP_TIE]; // [R14]
			assign o_touch_power_on[t] = regs_q[`RPC_IDX_TPAD0 + t][`RPC_TP_XPD]; // [R15]
			assign o_touch_input_to_digital[t] = regs_q[`RPC_IDX_TPAD0 + t][`RPC_TP_TODIG];
		end
	endgenerate

	// one-cycle start strobe on each rising edge of a start bit
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			start_prev_q <= '0;
		end else begin
			start_prev_q <= o_touch_start;
		end
	end

	assign o_touch_start_pulse = o_touch_start & ~start_prev_q; // [R15]

	// ============================================================
	// low-power I2C routing onto touch pads 0..3
	assign sda_sel = regs_q[`RPC_IDX_I2CSEL][`RPC_I2C_SDA];
	assign scl_sel = regs_q[`RPC_IDX_I2CSEL][`RPC_I2C_SCL];

	// function 1 of the chosen pads becomes the open-drain I2C line
	always_comb begin
		fn1_drv = i_lp_fn1_drv;
		if (scl_sel) begin // [R21]
			fn1_drv[`RPC_PAD_T0 + 2] = '{value: 1'b0, enable: i_i2c_scl_pull_low};
		end else begin
			fn1_drv[`RPC_PAD_T0 + 0] = '{value: 1'b0, enable: i_i2c_scl_pull_low};
		end
		if (sda_sel) begin // [R20]
			fn1_drv[`RPC_PAD_T0 + 3] = '{value: 1'b0, enable: i_i2c_sda_pull_low};
		end else begin
			fn1_drv[`RPC_PAD_T0 + 1] = '{value: 1'b0, enable: i_i2c_sda_pull_low};
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			i2c_scl_q <= 1'b1;
			i2c_sda_q <= 1'b1;
		end else begin
			i2c_scl_q <= scl_sel ? o_lp_in[`RPC_PAD_T0 + 2] : o_lp_in[`RPC_PAD_T0 + 0]; // [R21]
			i2c_sda_q <= sda_sel ? o_lp_in[`RPC_PAD_T0 + 3] : o_lp_in[`RPC_PAD_T0 + 1]; // [R20]
		end
	end

	assign o_i2c_scl_in = i2c_scl_q;
	assign o_i2c_sda_in = i2c_sda_q;

	// ============================================================
	// pad cells
	genvar p;
	generate
		for (p = 0; p < NPADS; p++) begin : g_pad
			rpc_pad_ctrl u_pad (
				.i_ref_clk(i_ref_clk),
				.i_sys_rst(i_sys_rst),
				.i_cfg(pad_cfg[p]),
				.i_dig_drv(i_dig_drv[p]),
				.i_lp_fn0_drv(i_lp_fn0_drv[p]),
				.i_lp_fn1_drv(fn1_drv[p]),
				.i_pad_in(i_pad_in[p]),
				.o_pad_out(o_pad_out[p]),
				.o_pad_oe_n(o_pad_oe_n[p]),
				.o_elec(o_pad_elec[p]),
				.o_dig_in(o_dig_in[p]),
				.o_lp_in(o_lp_in[p])
			);
		end
	endgenerate

	// ============================================================
	// converter controls; tristating the pad first is left to software
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			dac1_val_q <= '0;
			dac2_val_q <= '0;
			dac1_pwr_q <= 1'b0;
			dac2_pwr_q <= 1'b0;
		end else begin
			dac1_val_q <= regs_q[`RPC_IDX_DAC1][`RPC_DAC_VAL_MSB:`RPC_DAC_VAL_LSB]; // [R12]
			dac2_val_q <= regs_q[`RPC_IDX_DAC2][`RPC_DAC_VAL_MSB:`RPC_DAC_VAL_LSB]; // [R12]
			dac1_pwr_q <= regs_q[`RPC_IDX_DAC1][`RPC_DAC_PWR] | regs_q[`RPC_IDX_DAC1][`RPC_DAC_FORCE]; // [R12]
			dac2_pwr_q <= regs_q[`RPC_IDX_DAC2][`RPC_DAC_PWR] | regs_q[`RPC_IDX_DAC2][`RPC_DAC_FORCE];
		end
	end

	assign o_dac1_value = dac1_val_q;
	assign o_dac2_value = dac2_val_q;
	assign o_dac1_power_on = dac1_pwr_q;
	assign o_dac2_power_on = dac2_pwr_q;

	// ============================================================
	// slow crystal and touch bias controls
	assign o_slow_xtal_power_up = regs_q[`RPC_IDX_XTAL][`RPC_XT_PWR]; // [R22]
	assign o_slow_xtal_bias_dac = regs_q[`RPC_IDX_XTAL][`RPC_XT_BIAS_MSB:`RPC_XT_BIAS_LSB];
	assign o_slow_xtal_dres = regs_q[`RPC_IDX_XTAL][`RPC_XT_DRES_MSB:`RPC_XT_DRES_LSB];
	assign o_slow_xtal_dbias = regs_q[`RPC_IDX_XTAL][`RPC_XT_DBIAS_MSB:`RPC_XT_DBIAS_LSB];
	assign o_touch_bias_power = regs_q[`RPC_IDX_TGLOB][`RPC_TG_BIAS_PWR]; // [R16]
	assign o_touch_refh = regs_q[`RPC_IDX_TGLOB][`RPC_TG_DREFH_MSB:`RPC_TG_DREFH_LSB];
	assign o_touch_refl = regs_q[`RPC_IDX_TGLOB][`RPC_TG_DREFL_MSB:`RPC_TG_DREFL_LSB];
	assign o_touch_range = regs_q[`RPC_IDX_TGLOB][`RPC_TG_DRANGE_MSB:`RPC_TG_DRANGE_LSB];
	// current setting masked to zero unless bias sleep is on
	assign o_touch_bias_current = regs_q[`RPC_IDX_TGLOB][`RPC_TG_BIAS_SLEEP] // [R17]
		? regs_q[`RPC_IDX_TGLOB][`RPC_TG_TOUCH_BIAS_CURRENT_MSB:`RPC_TG_TOUCH_BIAS_CURRENT_LSB] : 2'h0;

	// ============================================================
	// wake-up and crystal power-down source selection
	rpc_pad_select #(
		.NLP(NLP)
	) u_select (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_lp_lvl(i_lp_pad_lvl),
		.i_wake_sel(regs_q[`RPC_IDX_WAKE][`RPC_SEL_MSB:`RPC_SEL_LSB]),
		.i_xpd_sel(regs_q[`RPC_IDX_XPDSEL][`RPC_SEL_MSB:`RPC_SEL_LSB]),
		.i_xtal_conf_invert(i_xtal_conf_invert),
		.o_wake_lvl(o_wake_lvl),
		.o_xtal_pd_en(o_xtal_pd_en)
	);

endmodule

/* File: tb/rpc_top_monitor.sv */
// concurrent checks on the APB and pad-side ports of the pad configuration block
// assumes it is bound into rpc_top, one clock, synchronous active-high reset
`include "rpc_consts.svh"

module rpc_top_monitor #(
	parameter int NPADS = `RPC_NPADS,
	parameter int NTOUCH = `RPC_NTOUCH
)
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [11:0] i_paddr,
	input wire logic o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic o_pslverr,
	input wire logic [NPADS-1:0] o_pad_out,
	input wire logic [NPADS-1:0] o_pad_oe_n,
	input wire logic [NPADS-1:0] o_dig_in,
	input wire logic [NPADS-1:0] o_lp_in,
	input wire logic [NTOUCH-1:0] o_touch_start,
	input wire logic [NTOUCH-1:0] o_touch_start_pulse,
	input wire logic o_i2c_scl_in,
	input wire logic o_i2c_sda_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// helpers
	wire setup = i_psel && !i_penable;
	wire mapped = i_paddr >= `RPC_OFS_FIRST && i_paddr <= `RPC_OFS_LAST && i_paddr[1:0] == 2'h0;

	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (i_sys_rst);

	// ============================================================
	// properties
	a_ready_access: assert property (i_psel && i_penable |-> o_pready)
		else $error("pready low in access phase");
	a_err_bad_addr: assert property (setup && !mapped |=> o_pslverr)
		else $error("unmapped access not flagged");
	a_err_good_addr: assert property (setup && mapped |=> !o_pslverr)
		else $error("mapped access flagged as error");
	a_err_data_zero: assert property (i_psel && i_penable && o_pslverr |-> o_prdata == 32'h0)
		else $error("read data not zero on error");
	a_rdata_stands: assert property (!setup |=> $stable(o_prdata) && $stable(o_pslverr))
		else $error("read data changed outside setup");
	a_route_exclusive: assert property ((o_dig_in & o_lp_in) == '0)
		else $error("pad input reached both domains");
	a_start_pulse_rise: assert property (o_touch_start_pulse == (o_touch_start & ~$past(o_touch_start)))
		else $error("start pulse not tied to start rise");
	a_reset_idle: assert property ($fell(i_sys_rst) |-> o_pad_oe_n == '1 && o_pad_out == '0
		&& o_i2c_sda_in && o_i2c_scl_in)
		else $error("pads not idle after reset");
endmodule

bind rpc_top rpc_top_monitor #(.NPADS(NPADS), .NTOUCH(NTOUCH)) u_mon (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
	.i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata),
	.o_pslverr(o_pslverr), .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n), .o_dig_in(o_dig_in), .o_lp_in(o_lp_in),
	.o_touch_start(o_touch_start), .o_touch_start_pulse(o_touch_start_pulse), .o_i2c_scl_in(o_i2c_scl_in),
	.o_i2c_sda_in(o_i2c_sda_in));

/* File: tb/tb_top.sv */
// self-checking bench for the pad configuration block driven over APB
// assumes rpc_top with its monitor bound in, one 100 MHz clock
`include "rpc_consts.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rpc_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0;
	logic pen = 1'h0;
	logic pwr = 1'h0;
	logic inv = 1'h0;
	logic [1:0] pl = 2'h0;
	logic [3:0] strb = 4'hF;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	rpc_drive_t [13:0] dig = '0;
	rpc_drive_t [13:0] fn0 = '0;
	rpc_drive_t [13:0] fn1 = '0;
	logic [13:0] pin = '0;
	logic [17:0] lvl = '0;
	logic rdy, err, wk, xpd, scl, sda, xpu, bpw, dp1, dp2;
	logic [31:0] rdata;
	logic [13:0] pout, poe_n, din, lin;
	rpc_pad_elec_t [13:0] elec;
	logic [7:0] dv1, dv2;
	logic [1:0] bcur;
	logic [9:0][2:0] slope;
	logic [9:0] start, tie, tpw, tdg;
	logic [1:0] xb, xr, xd, rh, rl, rg;
	logic [32:0] exp_q[$];
	logic [31:0] seed = 32'h553BD7F5;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;

	rpc_top dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(strb), .o_pready(rdy), .o_prdata(rdata), .o_pslverr(err), .i_dig_drv(dig),
		.i_lp_fn0_drv(fn0), .i_lp_fn1_drv(fn1), .i_pad_in(pin), .o_pad_out(pout), .o_pad_oe_n(poe_n),
		.o_pad_elec(elec), .o_dig_in(din), .o_lp_in(lin), .o_dac1_value(dv1), .o_dac1_power_on(dp1),
		.o_dac2_value(dv2), .o_dac2_power_on(dp2), .o_slow_xtal_power_up(xpu), .o_slow_xtal_bias_dac(xb),
		.o_slow_xtal_dres(xr), .o_slow_xtal_dbias(xd), .o_touch_bias_power(bpw), .o_touch_refh(rh),
		.o_touch_refl(rl), .o_touch_range(rg), .o_touch_bias_current(bcur), .o_touch_slope(slope),
		.o_touch_start(start), .o_touch_start_pulse(), .o_touch_tie_level(tie), .o_touch_power_on(tpw),
		.o_touch_input_to_digital(tdg), .i_lp_pad_lvl(lvl), .i_xtal_conf_invert(inv), .o_wake_lvl(wk),
		.o_xtal_pd_en(xpd), .i_i2c_scl_pull_low(pl[0]), .i_i2c_sda_pull_low(pl[1]), .o_i2c_scl_in(scl),
		.o_i2c_sda_in(sda));

	initial begin
		forever #5 clk = ~clk;
	end

	// ============================================================
	// helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] msk(input int i);
		if (i < 2) return `RPC_MSK_DAC;
		if (i == 2) return `RPC_MSK_XTAL;
		if (i == 3) return `RPC_MSK_TGLOB;
		if (i < 14) return `RPC_MSK_TPAD;
		if (i < 16) return `RPC_MSK_SEL;
		return `RPC_MSK_I2C;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (mismatches == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		@(posedge clk);
		while (rdy !== 1'h1) @(posedge clk);
		psel <= 1'h0;
		pen <= 1'h0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'h0, a, '0);
	endtask

	// pad cells lag the register write by one edge, pin inputs by three
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	// ============================================================
	// read data watcher and timeout
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (psel && pen && rdy === 1'h1 && !pwr) begin
			check({31'h0, err}, {31'h0, exp_q[0][32]});
			check(rdata, exp_q[0][31:0]);
			void'(exp_q.pop_front());
		end
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	// ============================================================
	// main sequence
	initial begin
		logic [31:0] r;
		logic [3:0] e4;
		rpc_pad_cfg_t c;
		rpc_drive_t s;
		logic ie;
		int p;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 17; i++) begin
			rd(12'h084 + 12'(4 * i), {1'h0, (i > 3 && i < 14) ? `RPC_RST_TPAD : `RPC_RST_ZERO});
		end
		check(32'(slope[0]), 32'h4);
		for (int i = 0; i < 17; i++) begin
			r = rnd() & msk(i);
			apb(1'h1, 12'h084 + 12'(4 * i), r);
			rd(12'h084 + 12'(4 * i), {1'h0, r});
		end
		rd(12'h0C8, {1'h1, 32'h0});
		rd(12'h086, {1'h1, 32'h0});
		rd(12'h080, {1'h1, 32'h0});
		apb(1'h1, 12'h094, 32'h0003_FFFF);
		strb <= 4'h1;
		apb(1'h1, 12'h094, 32'h0);
		strb <= 4'hF;
		rd(12'h094, {1'h0, 32'h0003_FF00});
		for (int k = 0; k < 24; k++) begin
			r = rnd();
			p = r[31:28] % 9;
			if (p > 2) p = p + 5;
			c = r[10:0];
			c.hold = 1'h0;
			@(posedge clk) dig <= 28'(rnd());
			fn0 <= 28'(rnd());
			fn1 <= 28'(rnd());
			pin <= 14'(rnd());
			apb(1'h1, 12'h084 + 12'(4 * p), {21'h0, c});
			settle();
			s = c.domain_route_select ? (c.lowpower_function_select ? fn1[p] : fn0[p]) : dig[p];
			ie = c.sleep_config_select ? c.sleep_input_enable : c.normal_input_enable;
			check(32'(poe_n[p]), 32'(c.sleep_config_select ? !c.sleep_output_enable : !s.enable));
			if (!c.sleep_config_select && s.enable) check(32'(pout[p]), 32'(s.value));
			check(32'(elec[p]),
				32'({c.drive_strength, c.pullup_enable, c.pulldown_enable, ie}));
			check(32'({din[p], lin[p]}),
				32'({!c.domain_route_select, c.domain_route_select} & {2{ie & pin[p]}}));
		end
		@(posedge clk) dig[0] <= 2'h3;
		apb(1'h1, 12'h084, 32'h0);
		settle();
		apb(1'h1, 12'h084, 32'h40);
		dig <= '0;
		settle();
		check(32'({pout[0], poe_n[0]}), 32'h2);
		apb(1'h1, 12'h084, 32'h0);
		settle();
		check(32'({pout[0], poe_n[0]}), 32'h1);
		for (int i = 0; i < 2; i++) begin
			r = rnd() & `RPC_MSK_DAC & 32'hFFFF_F800;
			apb(1'h1, 12'h084 + 12'(4 * i), r);
			settle();
			check(32'(i ? {dv2, dp2} : {dv1, dp1}), 32'({r[18:11], r[19] | r[20]}));
			check(32'({poe_n[i], elec[i]}), 32'h20);
		end
		r = rnd() & `RPC_MSK_XTAL;
		apb(1'h1, 12'h08C, r);
		settle();
		check(32'({xpu, xb, xr, xd}), 32'({r[24], r[23:22], r[26:25], r[28:27]}));
		for (int i = 0; i < 4; i++) begin
			r = rnd() & `RPC_MSK_TGLOB;
			r[9] = i[0];
			r[0] = i[1];
			apb(1'h1, 12'h090, r);
			settle();
			check(32'({bpw, bcur, rg, rl, rh}), 32'({r[0], (r[9] ? r[8:7] : 2'h0), r[6:1]}));
		end
		for (int n = 0; n < 10; n++) begin
			r = rnd() & `RPC_MSK_TPAD;
			apb(1'h1, 12'h094 + 12'(4 * n), r);
			settle();
			check(32'({tdg[n], tpw[n], tie[n], start[n], slope[n]}), 32'(r[17:11]));
		end
		for (int v = 0; v < 18; v++) begin
			@(posedge clk) lvl <= 18'(rnd());
			inv <= v[0];
			apb(1'h1, 12'h0BC, 32'(v));
			apb(1'h1, 12'h0C0, 32'(v));
			settle();
			check(32'({wk, xpd}), 32'({lvl[v], lvl[v] ^ inv}));
		end
		for (int n = 0; n < 4; n++) apb(1'h1, 12'h094 + 12'(4 * n), 32'h23);
		fn1 <= '0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) pin <= 14'(rnd());
			pl <= 2'(k + 1);
			apb(1'h1, 12'h0C4, 32'(k));
			settle();
			e4 = 4'hF;
			e4[k[0] ? 3 : 1] = !pl[1];
			e4[k[1] ? 2 : 0] = !pl[0];
			check(32'({sda, scl}), 32'({pin[k[0] ? 7 : 5], pin[k[1] ? 6 : 4]}));
			check(32'(poe_n[7:4]), 32'(e4));
		end
		give_verdict();
	end
endmodule
